/* File: design/dslk_defines.svh */
// Opcodes, sanitize subcommands, status codes and limits of the drive security lock
`ifndef DSLK_DEFINES_SVH
`define DSLK_DEFINES_SVH
// Security command opcodes
`define DSLK_OP_SET_PW        8'hf1
`define DSLK_OP_UNLOCK        8'hf2
`define DSLK_OP_ERASE_PREP    8'hf3
`define DSLK_OP_ERASE_UNIT    8'hf4
`define DSLK_OP_FREEZE        8'hf5
`define DSLK_OP_DISABLE_PW    8'hf6
// Media reads
`define DSLK_OP_RD_SEC        8'h20
`define DSLK_OP_RD_SEC_EXT    8'h24
`define DSLK_OP_RD_DMA_EXT    8'h25
`define DSLK_OP_RD_MULT_EXT   8'h29
`define DSLK_OP_RD_STRM_DMA   8'h2a
`define DSLK_OP_RD_STRM       8'h2b
`define DSLK_OP_RD_VFY        8'h40
`define DSLK_OP_RD_VFY_EXT    8'h42
`define DSLK_OP_RD_FPDMA      8'h60
`define DSLK_OP_RD_MULT       8'hc4
`define DSLK_OP_RD_DMA        8'hc8
// Media writes
`define DSLK_OP_WR_SEC        8'h30
`define DSLK_OP_WR_SEC_EXT    8'h34
`define DSLK_OP_WR_DMA_EXT    8'h35
`define DSLK_OP_WR_MULT_EXT   8'h39
`define DSLK_OP_WR_STRM_DMA   8'h3a
`define DSLK_OP_WR_STRM       8'h3b
`define DSLK_OP_WR_DMA_FUA    8'h3d
`define DSLK_OP_WR_LOG_EXT    8'h3f
`define DSLK_OP_WR_UNC_EXT    8'h45
`define DSLK_OP_WR_LOG_DMA    8'h57
`define DSLK_OP_WR_FPDMA      8'h61
`define DSLK_OP_WR_MULT       8'hc5
`define DSLK_OP_WR_DMA        8'hca
`define DSLK_OP_WR_MULT_FUA   8'hce
// Configuration and maintenance
`define DSLK_OP_CFG_STREAM    8'h51
`define DSLK_OP_NCQ_NODATA    8'h63
`define DSLK_OP_DL_UCODE      8'h92
`define DSLK_OP_DL_UCODE_DMA  8'h93
`define DSLK_OP_DEV_CFG       8'hb1
`define DSLK_OP_SANITIZE      8'hb4
`define DSLK_OP_FLUSH         8'he7
`define DSLK_OP_FLUSH_EXT     8'hea
`define DSLK_OP_SET_MAX       8'hf9
`define DSLK_OP_SET_MAX_EXT   8'h37
`define DSLK_OP_TRUST_RCV     8'h5c
`define DSLK_OP_TRUST_RCV_DMA 8'h5d
`define DSLK_OP_TRUST_SND     8'h5e
`define DSLK_OP_TRUST_SND_DMA 8'h5f
// Sanitize subcommands carried in the feature byte
`define DSLK_SAN_CRYPTO       8'h11
`define DSLK_SAN_OVERWRITE    8'h14
`define DSLK_SAN_FREEZE       8'h20
// Status and error bytes
`define DSLK_STAT_OK          8'h50
`define DSLK_STAT_ERR         8'h51
`define DSLK_ERR_ABORT        8'h04
// Master revision code limits and shipped default
`define DSLK_REV_MIN          16'h0001
`define DSLK_REV_MAX          16'hfffe
`define DSLK_REV_DEFAULT      16'hfffe
// Mismatch limit and identify word 128 fields
`define DSLK_ATTEMPT_LIMIT    3'h5
`define DSLK_W128_SUPPORTED   0
`define DSLK_W128_ENABLED     1
`define DSLK_W128_LOCKED      2
`define DSLK_W128_FROZEN      3
`define DSLK_W128_EXPIRED     4
`define DSLK_W128_LEVEL_MAX   8
`endif

/* File: design/dslk_pkg.sv */
// Types of the drive security lock state machine
package dslk_pkg;
	// Security mode, one-hot
	typedef enum logic [2:0] {
		DSLK_LOCKED   = 3'b001,
		DSLK_UNLOCKED = 3'b010,
		DSLK_FROZEN   = 3'b100
	} dslk_mode_t;

	// Command as handed over by the command decoder
	typedef struct packed {
		logic        valid;
		logic [7:0]  opcode;
		logic [7:0]  feature;
		logic        pw_master;
		logic        pw_match;
		logic        level_max;
		logic [15:0] rev_code;
	} dslk_cmd_t;

	// Verdict on one command
	typedef struct packed {
		logic       done;
		logic       execute;
		logic       aborted;
		logic       erase_start;
		logic [7:0] status;
		logic [7:0] error;
	} dslk_rsp_t;
endpackage

/* File: design/dslk_lock_fsm.sv */
// Security lock state machine and command gate of the drive front end
`timescale 1ns/10ps
`include "dslk_defines.svh"

module dslk_lock_fsm (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire dslk_pkg::dslk_cmd_t cmd,
	input  wire logic              tcg_active,
	input  wire logic              nv_lock_en,
	input  wire logic              nv_level_max,
	input  wire logic [15:0]       nv_master_rev,
	output dslk_pkg::dslk_rsp_t    rsp,
	output dslk_pkg::dslk_mode_t   mode,
	output logic                   lock_en,
	output logic                   level_max,
	output logic [15:0]            id_word92,
	output logic [15:0]            id_word128
);

	// Command class decode
	logic is_sec;
	logic is_lock_gated;
	logic is_erase_unit;

	// Security commands by opcode
	always_comb begin
		is_sec        = 1'b0;
		is_erase_unit = 1'b0;
		unique case (cmd.opcode)
			`DSLK_OP_SET_PW, `DSLK_OP_UNLOCK, `DSLK_OP_ERASE_PREP: begin
				is_sec = 1'b1;
			end
			`DSLK_OP_ERASE_UNIT: begin
				is_sec        = 1'b1;
				is_erase_unit = 1'b1;
			end
			`DSLK_OP_FREEZE, `DSLK_OP_DISABLE_PW: begin
				is_sec = 1'b1;
			end
			default: begin
				is_sec = 1'b0;
			end
		endcase
	end

	// Commands refused only in locked mode; any other non-security command always runs
	always_comb begin
		is_lock_gated = 1'b0;
		unique case (cmd.opcode)
			`DSLK_OP_RD_SEC, `DSLK_OP_RD_SEC_EXT, `DSLK_OP_RD_DMA, `DSLK_OP_RD_DMA_EXT,
			`DSLK_OP_RD_MULT, `DSLK_OP_RD_MULT_EXT, `DSLK_OP_RD_FPDMA, `DSLK_OP_RD_STRM,
			`DSLK_OP_RD_STRM_DMA, `DSLK_OP_RD_VFY, `DSLK_OP_RD_VFY_EXT: begin
				is_lock_gated = 1'b1;
			end
			`DSLK_OP_WR_SEC, `DSLK_OP_WR_SEC_EXT, `DSLK_OP_WR_DMA, `DSLK_OP_WR_DMA_EXT,
			`DSLK_OP_WR_MULT, `DSLK_OP_WR_MULT_EXT, `DSLK_OP_WR_MULT_FUA, `DSLK_OP_WR_DMA_FUA,
			`DSLK_OP_WR_FPDMA, `DSLK_OP_WR_STRM, `DSLK_OP_WR_STRM_DMA, `DSLK_OP_WR_UNC_EXT,
			`DSLK_OP_WR_LOG_EXT, `DSLK_OP_WR_LOG_DMA: begin
				is_lock_gated = 1'b1;
			end
			`DSLK_OP_CFG_STREAM, `DSLK_OP_NCQ_NODATA, `DSLK_OP_DL_UCODE, `DSLK_OP_DL_UCODE_DMA,
			`DSLK_OP_DEV_CFG, `DSLK_OP_FLUSH, `DSLK_OP_FLUSH_EXT: begin
				is_lock_gated = 1'b1;
			end
			`DSLK_OP_SET_MAX, `DSLK_OP_SET_MAX_EXT, `DSLK_OP_TRUST_RCV, `DSLK_OP_TRUST_RCV_DMA,
			`DSLK_OP_TRUST_SND, `DSLK_OP_TRUST_SND_DMA: begin
				is_lock_gated = 1'b1;
			end
			`DSLK_OP_SANITIZE: begin
				// Sanitize status stays open so a locked drive can still report
				is_lock_gated = (cmd.feature == `DSLK_SAN_CRYPTO) ||
				                (cmd.feature == `DSLK_SAN_OVERWRITE) ||
				                (cmd.feature == `DSLK_SAN_FREEZE);
			end
			default: begin
				is_lock_gated = 1'b0;
			end
		endcase
	end

	// Security state
	dslk_pkg::dslk_mode_t mode_r, mode_nxt;
	logic        lock_en_r, lock_en_nxt;
	logic        level_max_r, level_max_nxt;
	logic [15:0] master_rev_r, master_rev_nxt;
	logic [2:0]  miss_cnt_r, miss_cnt_nxt;
	logic        expired_r, expired_nxt;
	logic        erase_armed_r, erase_armed_nxt;
	dslk_pkg::dslk_rsp_t rsp_r, rsp_nxt;

	// Working terms of the current command
	logic mode_abort;
	logic sec_ok;
	logic pw_fail;

	// Next state of mode, passwords, counter and verdict
	always_comb begin
		mode_nxt        = mode_r;
		lock_en_nxt     = lock_en_r;
		level_max_nxt   = level_max_r;
		master_rev_nxt  = master_rev_r;
		miss_cnt_nxt    = miss_cnt_r;
		expired_nxt     = expired_r;
		erase_armed_nxt = erase_armed_r;
		rsp_nxt         = '0;
		mode_abort      = 1'b0;
		sec_ok          = 1'b0;
		pw_fail         = 1'b0;
		if (cmd.valid) begin
			// Erase unit must follow erase prepare directly
			erase_armed_nxt = 1'b0;
			if (is_sec) begin
				if (tcg_active) begin
					mode_abort = 1'b1;
				end else begin
					unique case (cmd.opcode)
						`DSLK_OP_SET_PW: begin
							mode_abort = (mode_r != dslk_pkg::DSLK_UNLOCKED);
							if (!mode_abort && cmd.pw_master) begin
								// Out-of-range codes leave the stored revision as it was
								if (cmd.rev_code >= `DSLK_REV_MIN && cmd.rev_code <= `DSLK_REV_MAX) begin
									master_rev_nxt = cmd.rev_code;
								end
							end else if (!mode_abort) begin
								lock_en_nxt   = 1'b1;
								level_max_nxt = cmd.level_max;
							end
						end
						`DSLK_OP_UNLOCK: begin
							// Match covers user or master; the level decides whether master may open
							mode_abort = (mode_r == dslk_pkg::DSLK_FROZEN) || expired_r;
							if (!mode_abort && cmd.pw_master && level_max_r) begin
								mode_abort = 1'b1;
							end else if (!mode_abort && cmd.pw_match) begin
								sec_ok   = 1'b1;
								mode_nxt = dslk_pkg::DSLK_UNLOCKED;
							end else if (!mode_abort) begin
								pw_fail = 1'b1;
							end
						end
						`DSLK_OP_ERASE_PREP: begin
							mode_abort = (mode_r == dslk_pkg::DSLK_FROZEN);
							erase_armed_nxt = !mode_abort;
						end
						`DSLK_OP_ERASE_UNIT: begin
							// Only way back for a master password at maximum level; data goes with it
							mode_abort = (mode_r == dslk_pkg::DSLK_FROZEN) || expired_r || !erase_armed_r;
							if (!mode_abort && cmd.pw_match) begin
								sec_ok      = 1'b1;
								mode_nxt    = dslk_pkg::DSLK_UNLOCKED;
								lock_en_nxt = 1'b0;
							end else if (!mode_abort) begin
								pw_fail = 1'b1;
							end
						end
						`DSLK_OP_FREEZE: begin
							mode_abort = (mode_r == dslk_pkg::DSLK_LOCKED);
							if (!mode_abort) begin
								mode_nxt = dslk_pkg::DSLK_FROZEN;
							end
						end
						`DSLK_OP_DISABLE_PW: begin
							mode_abort = (mode_r != dslk_pkg::DSLK_UNLOCKED);
							if (!mode_abort && cmd.pw_match) begin
								lock_en_nxt = 1'b0;
							end else if (!mode_abort) begin
								mode_abort = 1'b1;
							end
						end
						default: begin
							mode_abort = 1'b1;
						end
					endcase
				end
			end else begin
				mode_abort = is_lock_gated && (mode_r == dslk_pkg::DSLK_LOCKED);
			end
			// Mismatch counter saturates at the limit
			if (pw_fail && !expired_r) begin
				miss_cnt_nxt = 3'(miss_cnt_r + 3'h1);
				expired_nxt  = (miss_cnt_nxt == `DSLK_ATTEMPT_LIMIT);
			end
			// Verdict; a failed compare answers aborted just like a gated command
			rsp_nxt.done        = 1'b1;
			rsp_nxt.aborted     = mode_abort || pw_fail;
			rsp_nxt.execute     = !(mode_abort || pw_fail);
			rsp_nxt.erase_start = sec_ok && is_erase_unit;
			rsp_nxt.status      = (mode_abort || pw_fail) ? `DSLK_STAT_ERR : `DSLK_STAT_OK;
			rsp_nxt.error       = (mode_abort || pw_fail) ? `DSLK_ERR_ABORT : 8'h00;
		end
	end

	// Registers; reset loads the persisted lock setup
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_r        <= nv_lock_en ? dslk_pkg::DSLK_LOCKED : dslk_pkg::DSLK_UNLOCKED;
			lock_en_r     <= nv_lock_en;
			level_max_r   <= nv_level_max;
			master_rev_r  <= (nv_master_rev >= `DSLK_REV_MIN && nv_master_rev <= `DSLK_REV_MAX) ?
			                 nv_master_rev : `DSLK_REV_DEFAULT;
			miss_cnt_r    <= 3'h0;
			expired_r     <= 1'b0;
			erase_armed_r <= 1'b0;
			rsp_r         <= '0;
		end else begin
			mode_r        <= mode_nxt;
			lock_en_r     <= lock_en_nxt;
			level_max_r   <= level_max_nxt;
			master_rev_r  <= master_rev_nxt;
			miss_cnt_r    <= miss_cnt_nxt;
			expired_r     <= expired_nxt;
			erase_armed_r <= erase_armed_nxt;
			rsp_r         <= rsp_nxt;
		end
	end

	// Identify words and state outputs, all from flip-flops
	always_comb begin
		id_word128                       = 16'h0000;
		id_word128[`DSLK_W128_SUPPORTED] = 1'b1;
		id_word128[`DSLK_W128_ENABLED]   = lock_en_r;
		id_word128[`DSLK_W128_LOCKED]    = (mode_r == dslk_pkg::DSLK_LOCKED);
		id_word128[`DSLK_W128_FROZEN]    = (mode_r == dslk_pkg::DSLK_FROZEN);
		id_word128[`DSLK_W128_EXPIRED]   = expired_r;
		id_word128[`DSLK_W128_LEVEL_MAX] = level_max_r;
	end

	assign id_word92 = master_rev_r;
	assign rsp       = rsp_r;
	assign mode      = mode_r;
	assign lock_en   = lock_en_r;
	assign level_max = level_max_r;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_locked_cmd(gated);
		cmd.valid && mode_r == dslk_pkg::DSLK_LOCKED && gated;
	endsequence

	sequence s_answer_abort;
		rsp.done && rsp.aborted && rsp.error == `DSLK_ERR_ABORT;
	endsequence

	sequence s_answer_ok;
		rsp.done && rsp.execute && rsp.status == `DSLK_STAT_OK;
	endsequence

	// Erase unit as it reaches the security decode
	sequence s_erase_unit_cmd;
		cmd.valid && cmd.opcode == `DSLK_OP_ERASE_UNIT;
	endsequence

	// Mode gate on ordinary commands
	a_gate_locked_media: assert property (s_locked_cmd(is_lock_gated && !is_sec) |=> s_answer_abort)
		else $error("gated command executed in locked mode");
	a_gate_open_cmds: assert property (cmd.valid && !is_sec && !is_lock_gated |=> rsp.execute)
		else $error("always-open command aborted");

	// Security refusals
	a_tcg_blocks_sec: assert property (cmd.valid && is_sec && tcg_active |=> s_answer_abort ##0 $stable(mode_r))
		else $error("security command ran with trusted computing active");
	a_frozen_sticks: assert property (mode_r == dslk_pkg::DSLK_FROZEN |=> mode_r == dslk_pkg::DSLK_FROZEN)
		else $error("left frozen mode without reset");
	a_frozen_refuses: assert property (cmd.valid && mode_r == dslk_pkg::DSLK_FROZEN && is_sec &&
		cmd.opcode != `DSLK_OP_FREEZE |=> s_answer_abort ##0 $stable(lock_en_r) ##0 $stable(master_rev_r))
		else $error("lock or password change accepted in frozen mode");

	// Attempt limit
	a_expiry_at_five: assert property (expired_r == (miss_cnt_r == `DSLK_ATTEMPT_LIMIT))
		else $error("expiry flag disagrees with mismatch count");
	a_expired_unlock: assert property (cmd.valid && expired_r &&
		(is_erase_unit || cmd.opcode == `DSLK_OP_UNLOCK) |=> s_answer_abort ##0 (mode_r == $past(mode_r)))
		else $error("unlock accepted after attempts exhausted");
	a_miss_counts: assert property (cmd.valid && !tcg_active && !expired_r && cmd.opcode == `DSLK_OP_UNLOCK &&
		mode_r != dslk_pkg::DSLK_FROZEN && !cmd.pw_match && !(cmd.pw_master && level_max_r)
		|=> miss_cnt_r == $past(miss_cnt_r) + 3'h1)
		else $error("failed unlock not counted");

	// Passwords, levels and revision code
	a_master_no_lock: assert property (cmd.valid && cmd.opcode == `DSLK_OP_SET_PW && cmd.pw_master
		|=> lock_en_r == $past(lock_en_r))
		else $error("master password changed lock enable");
	a_max_level_master: assert property (cmd.valid && cmd.opcode == `DSLK_OP_UNLOCK &&
		cmd.pw_master && level_max_r |=> mode_r == $past(mode_r) ##0 rsp.aborted)
		else $error("master unlock accepted at maximum level");
	a_rev_in_range: assert property (id_word92 >= `DSLK_REV_MIN && id_word92 <= `DSLK_REV_MAX)
		else $error("master revision out of range");
	a_user_pw_enables: assert property (cmd.valid && !tcg_active && cmd.opcode == `DSLK_OP_SET_PW &&
		!cmd.pw_master && mode_r == dslk_pkg::DSLK_UNLOCKED |=> lock_en_r && mode_r == dslk_pkg::DSLK_UNLOCKED)
		else $error("user password did not enable lock");
	a_level_kept: assert property (!(cmd.valid && cmd.opcode == `DSLK_OP_SET_PW) |=> $stable(level_max_r))
		else $error("security level moved without a password set");

	// Persisted setup and cleared attempt count after reset; the first two watch reset itself
	a_reset_mode: assert property (disable iff (1'b0) !rst_n |=>
		mode_r == ($past(nv_lock_en) ? dslk_pkg::DSLK_LOCKED : dslk_pkg::DSLK_UNLOCKED))
		else $error("reset mode disagrees with persisted lock enable");
	a_reset_clears: assert property (disable iff (1'b0) !rst_n |=> miss_cnt_r == 3'h0 && !expired_r)
		else $error("reset left attempt count or expiry set");
	a_count_holds: assert property (miss_cnt_r != 3'h0 |=> miss_cnt_r >= $past(miss_cnt_r))
		else $error("mismatch count dropped without reset");

	// Every taken command answers once, one cycle later, with consistent codes
	a_one_answer: assert property (cmd.valid |=> rsp.done)
		else $error("command left without an answer");
	a_no_stray_answer: assert property (!cmd.valid |=> !rsp.done)
		else $error("answer without a command");
	a_verdict_codes: assert property (rsp.done |-> (rsp.execute != rsp.aborted) &&
		rsp.status == (rsp.aborted ? `DSLK_STAT_ERR : `DSLK_STAT_OK) && rsp.error == (rsp.aborted ? `DSLK_ERR_ABORT : 8'h00))
		else $error("verdict codes disagree with abort flag");

	// Erase unit pairs with the prepare just before it
	a_erase_needs_arm: assert property (s_erase_unit_cmd ##0 !erase_armed_r |=> s_answer_abort)
		else $error("erase unit ran without a prepare");
	a_erase_opens: assert property (rsp.erase_start |-> rsp.execute && mode_r == dslk_pkg::DSLK_UNLOCKED && !lock_en_r)
		else $error("erase start without an opened drive");

	// Mode moves of freeze and unlock
	a_freeze_enters: assert property (cmd.valid && !tcg_active && cmd.opcode == `DSLK_OP_FREEZE &&
		mode_r != dslk_pkg::DSLK_LOCKED |=> s_answer_ok ##0 mode_r == dslk_pkg::DSLK_FROZEN)
		else $error("freeze lock did not enter frozen mode");
	a_unlock_opens: assert property (cmd.valid && !tcg_active && cmd.opcode == `DSLK_OP_UNLOCK && !expired_r &&
		mode_r != dslk_pkg::DSLK_FROZEN && cmd.pw_match && !(cmd.pw_master && level_max_r)
		|=> s_answer_ok ##0 mode_r == dslk_pkg::DSLK_UNLOCKED)
		else $error("matching unlock did not open the drive");

endmodule

/* File: verification/dslk_host_model.sv */
// Host-side command issuer that faces the security lock block
`timescale 1ns/10ps
`include "dslk_defines.svh"

module dslk_host_model (
	input  wire logic                clk,
	output dslk_pkg::dslk_cmd_t      cmd,
	input  wire dslk_pkg::dslk_rsp_t rsp
);
	initial cmd = '0;

	// One command a call, taken at the next edge; idle fields scrambled so stale values never help
	task automatic issue(input logic [7:0] op, input logic [7:0] ft, input logic m, input logic pm,
		input logic lvl, input logic [15:0] rev, output dslk_pkg::dslk_rsp_t r, output logic ok);
		int n;
		cmd = '{valid: 1'b1, opcode: op, feature: ft, pw_master: m, pw_match: pm, level_max: lvl, rev_code: rev};
		@(posedge clk);
		#1;
		cmd = {1'b0, ~cmd[$bits(cmd)-2:0]};
		ok = 1'b0;
		r = '0;
		// Bounded wait for the one-cycle answer
		for (n = 0; n < 3 && !ok; n++) begin
			if (rsp.done === 1'b1) begin
				r = rsp;
				ok = 1'b1;
			end else begin
				@(posedge clk);
				#1;
			end
		end
		@(posedge clk);
		#1;
	endtask
endmodule

/* File: verification/drive_security_lock_fsm_test.sv */
// Self-checking bench of the drive security lock state machine
`timescale 1ns/10ps
`include "dslk_defines.svh"

module drive_security_lock_fsm_test;
	logic                 clk;
	logic                 rst_n;
	logic                 tcg_active;
	logic                 nv_lock_en;
	logic                 nv_level_max;
	logic [15:0]          nv_master_rev;
	dslk_pkg::dslk_cmd_t  cmd;
	dslk_pkg::dslk_rsp_t  rsp;
	dslk_pkg::dslk_mode_t mode;
	logic                 lock_en;
	logic                 level_max;
	logic [15:0]          id_word92;
	logic [15:0]          id_word128;
	logic                 lvl_g;
	logic [15:0]          rev_g;
	int                   fail_count;
	int                   checked;
	int                   i;
	// Opcode and feature pairs refused while locked, executable elsewhere
	logic [15:0] gated [41] = '{16'h2000, 16'h2400, 16'h2500, 16'h2900, 16'h2a00, 16'h2b00, 16'h4000,
		16'h4200, 16'h6000, 16'hc400, 16'hc800, 16'h3000, 16'h3400, 16'h3500, 16'h3900, 16'h3a00, 16'h3b00,
		16'h3d00, 16'h3f00, 16'h4500, 16'h5700, 16'h6100, 16'hc500, 16'hca00, 16'hce00, 16'h5100, 16'h6300,
		16'h9200, 16'h9300, 16'hb100, 16'he700, 16'hea00, 16'hb411, 16'hb414, 16'hb420,
		16'hf900, 16'h3700, 16'h5c00, 16'h5d00, 16'h5e00, 16'h5f00};
	// Commands that run in every mode
	logic [15:0] always_ok [14] = '{16'he500, 16'h9000, 16'hec00, 16'he300, 16'he100, 16'h9100, 16'he400,
		16'h2f00, 16'h4700, 16'h1000, 16'h0b00, 16'hf800, 16'h2700, 16'hb400};

	dslk_lock_fsm DUT (.clk(clk), .rst_n(rst_n), .cmd(cmd), .tcg_active(tcg_active), .nv_lock_en(nv_lock_en),
		.nv_level_max(nv_level_max), .nv_master_rev(nv_master_rev), .rsp(rsp), .mode(mode),
		.lock_en(lock_en), .level_max(level_max), .id_word92(id_word92), .id_word128(id_word128));
	dslk_host_model host (.clk(clk), .cmd(cmd), .rsp(rsp));

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic results();
		if (fail_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Expected identify word 128 from the mode flags
	function automatic logic [15:0] w128(input logic le, input logic lk, input logic fr, input logic ex,
		input logic lv);
		return {7'h00, lv, 3'h0, ex, fr, lk, le, 1'b1};
	endfunction

	// Power-on or hard reset with the persisted state applied
	task automatic pwr_reset(input logic le, input logic lv, input logic [15:0] rev);
		rst_n = 1'b0;
		nv_lock_en = le;
		nv_level_max = lv;
		nv_master_rev = rev;
		repeat (20) @(posedge clk);
		#1;
		rst_n = 1'b1;
	endtask

	task automatic run(input logic [7:0] op, input logic [7:0] ft, input logic m, input logic pm,
		input logic ok_exp);
		dslk_pkg::dslk_rsp_t r;
		logic                ok;
		host.issue(op, ft, m, pm, lvl_g, rev_g, r, ok);
		if (!ok) begin
			fail_count++;
			$display("MISMATCH %0t no answer to %h", $time, op);
			results();
		end else begin
			chk({12'h0, r.erase_start, r.execute, r.aborted, r.done},
				{12'h0, ok_exp && (op == `DSLK_OP_ERASE_UNIT), ok_exp, !ok_exp, 1'b1}, $sformatf("op %h verdict", op));
			chk({r.status, r.error}, ok_exp ? {`DSLK_STAT_OK, 8'h00} : {`DSLK_STAT_ERR, `DSLK_ERR_ABORT},
				$sformatf("op %h status", op));
		end
	endtask

	task automatic chk_mode(input dslk_pkg::dslk_mode_t m);
		chk({13'h0, mode}, {13'h0, m}, "mode");
	endtask

	// Locked after reset: gate sweep, security refusals, then unlock
	task automatic t_locked();
		pwr_reset(1'b1, 1'b0, 16'h0000);
		chk_mode(dslk_pkg::DSLK_LOCKED);
		chk(id_word92, `DSLK_REV_DEFAULT, "rev default");
		chk(id_word128, w128(1'b1, 1'b1, 1'b0, 1'b0, 1'b0), "w128 locked");
		for (i = 0; i < 41; i++) run(gated[i][15:8], gated[i][7:0], 1'b0, 1'b1, 1'b0);
		for (i = 0; i < 14; i++) run(always_ok[i][15:8], always_ok[i][7:0], 1'b0, 1'b1, 1'b1);
		run(`DSLK_OP_FREEZE, 8'h00, 1'b0, 1'b1, 1'b0);
		run(`DSLK_OP_SET_PW, 8'h00, 1'b0, 1'b1, 1'b0);
		chk_mode(dslk_pkg::DSLK_LOCKED);
		run(`DSLK_OP_UNLOCK, 8'h00, 1'b0, 1'b1, 1'b1);
		chk_mode(dslk_pkg::DSLK_UNLOCKED);
		for (i = 0; i < 41; i++) run(gated[i][15:8], gated[i][7:0], 1'b0, 1'b1, 1'b1);
	endtask

	// Frozen mode refuses every lock change until the next reset
	task automatic t_freeze();
		run(`DSLK_OP_FREEZE, 8'h00, 1'b0, 1'b1, 1'b1);
		chk_mode(dslk_pkg::DSLK_FROZEN);
		chk(id_word128, w128(1'b1, 1'b0, 1'b1, 1'b0, 1'b0), "w128 frozen");
		for (i = 1; i < 5; i++) run(8'hf0 + i[7:0], 8'h00, 1'b0, 1'b1, 1'b0);
		run(`DSLK_OP_FREEZE, 8'h00, 1'b0, 1'b1, 1'b1);
		run(`DSLK_OP_DISABLE_PW, 8'h00, 1'b0, 1'b1, 1'b0);
		for (i = 0; i < 41; i++) run(gated[i][15:8], gated[i][7:0], 1'b0, 1'b1, 1'b1);
		chk_mode(dslk_pkg::DSLK_FROZEN);
		pwr_reset(1'b0, 1'b0, 16'h1111);
		chk_mode(dslk_pkg::DSLK_UNLOCKED);
	endtask

	// Five mismatches of mixed kind unlock_attempts_exhausted unlocking until reset
	task automatic t_attempts();
		pwr_reset(1'b1, 1'b0, 16'h1111);
		for (i = 0; i < 5; i++) begin
			chk(id_word128[4], 1'b0, "expired early");
			run(`DSLK_OP_UNLOCK, 8'h00, i[0], 1'b0, 1'b0);
		end
		chk(id_word128, w128(1'b1, 1'b1, 1'b0, 1'b1, 1'b0), "w128 expired");
		run(`DSLK_OP_UNLOCK, 8'h00, 1'b0, 1'b1, 1'b0);
		run(`DSLK_OP_ERASE_PREP, 8'h00, 1'b0, 1'b1, 1'b1);
		run(`DSLK_OP_ERASE_UNIT, 8'h00, 1'b0, 1'b1, 1'b0);
		pwr_reset(1'b1, 1'b0, 16'h1111);
		chk(id_word128[4], 1'b0, "expiry cleared");
		run(`DSLK_OP_UNLOCK, 8'h00, 1'b1, 1'b1, 1'b1);
		chk_mode(dslk_pkg::DSLK_UNLOCKED);
	endtask

	// Maximum level: master works only through prepare and erase unit
	task automatic t_max_level();
		pwr_reset(1'b1, 1'b1, 16'h1111);
		chk(id_word128[8], 1'b1, "level bit");
		run(`DSLK_OP_UNLOCK, 8'h00, 1'b1, 1'b1, 1'b0);
		run(`DSLK_OP_ERASE_UNIT, 8'h00, 1'b1, 1'b1, 1'b0);
		run(`DSLK_OP_ERASE_PREP, 8'h00, 1'b1, 1'b1, 1'b1);
		chk_mode(dslk_pkg::DSLK_LOCKED);
		run(`DSLK_OP_ERASE_UNIT, 8'h00, 1'b1, 1'b1, 1'b1);
		chk_mode(dslk_pkg::DSLK_UNLOCKED);
		chk(lock_en, 1'b0, "lock after erase");
	endtask

	// Master password never locks; user password locks from the next reset
	task automatic t_passwords();
		pwr_reset(1'b0, 1'b0, 16'h1111);
		chk(id_word92, 16'h1111, "rev kept");
		rev_g = 16'h2222;
		run(`DSLK_OP_SET_PW, 8'h00, 1'b1, 1'b1, 1'b1);
		chk({lock_en, id_word92}, {1'b0, 16'h2222}, "master set");
		rev_g = 16'hffff;
		run(`DSLK_OP_SET_PW, 8'h00, 1'b1, 1'b1, 1'b1);
		chk(id_word92, 16'h2222, "rev out of range kept");
		lvl_g = 1'b1;
		run(`DSLK_OP_SET_PW, 8'h00, 1'b0, 1'b1, 1'b1);
		chk({lock_en, level_max}, 2'b11, "user set");
		chk_mode(dslk_pkg::DSLK_UNLOCKED);
		pwr_reset(lock_en, level_max, id_word92);
		chk_mode(dslk_pkg::DSLK_LOCKED);
		lvl_g = 1'b0;
	endtask

	// Trusted computing active: every security opcode refused
	task automatic t_tcg();
		pwr_reset(1'b0, 1'b0, 16'h1111);
		tcg_active = 1'b1;
		for (i = 1; i < 7; i++) run(8'hf0 + i[7:0], 8'h00, 1'b0, 1'b1, 1'b0);
		chk_mode(dslk_pkg::DSLK_UNLOCKED);
		tcg_active = 1'b0;
		run(`DSLK_OP_DISABLE_PW, 8'h00, 1'b0, 1'b0, 1'b0);
		run(`DSLK_OP_FREEZE, 8'h00, 1'b0, 1'b1, 1'b1);
		chk_mode(dslk_pkg::DSLK_FROZEN);
	endtask

	// Main sequence
	initial begin
		rst_n = 1'b0;
		tcg_active = 1'b0;
		nv_lock_en = 1'b0;
		nv_level_max = 1'b0;
		nv_master_rev = 16'h0000;
		lvl_g = 1'b0;
		rev_g = 16'h0000;
		fail_count = 0;
		checked = 0;
		@(posedge clk);
		#1;
		t_locked();
		t_freeze();
		t_attempts();
		t_max_level();
		t_passwords();
		t_tcg();
		results();
	end
endmodule
